// ===== rtl/tac_serial_slave.v
// Two-wire serial slave of the thermal alarm comparator, sampled on pclk
`timescale 1ns/100ps
`include "tac_defines.vh"
module tac_serial_slave #(
    parameter TMO_CYC = `TAC_TMO_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire scl_i,
    input wire sda_i,
    input wire [2:0] addr_pins,
    input wire [15:0] rd_word,
    output reg sda_oe_n_reg,
    output reg [1:0] ptr_reg,
    output reg busy_reg,
    output reg rd_pulse_reg,
    output reg wr_pulse_reg,
    output reg [15:0] wr_data_reg,
    output reg tmo_pulse_reg
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_ADDR = 4'b0010;
    localparam ST_WR = 4'b0100;
    localparam ST_RD = 4'b1000;

    reg [2:0] scl_sync_reg;
    reg [2:0] sda_sync_reg;
    reg [2:0] a1_reg;
    reg [2:0] a2_reg;
    reg [3:0] st_reg;
    reg [3:0] cnt_reg;
    reg [7:0] sh_reg;
    reg [15:0] tx_reg;
    reg [1:0] idx_reg;
    reg mack_reg;
    reg [22:0] low_cnt_reg;
    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire addr_hit;

    // Pin synchronisers, stage 0 feeds only stage 1
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            a1_reg <= 3'h0;
            a2_reg <= 3'h0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
            a1_reg <= addr_pins;
            a2_reg <= a1_reg;
        end
    end

    // Edge and condition detection on synchronised lines
    assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
    assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
    assign start_cond = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
    assign stop_cond = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];
    assign addr_hit = (sh_reg[7:1] == {`TAC_ADDR_HI, a2_reg});

    // Protocol engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_reg <= 16'h0000;
            idx_reg <= 2'h0;
            mack_reg <= 1'b0;
            ptr_reg <= `TAC_PTR_TEMP;
            sda_oe_n_reg <= 1'b1;
            busy_reg <= 1'b0;
            rd_pulse_reg <= 1'b0;
            wr_pulse_reg <= 1'b0;
            wr_data_reg <= 16'h0000;
            tmo_pulse_reg <= 1'b0;
            low_cnt_reg <= 23'h000000;
        end else begin
            rd_pulse_reg <= 1'b0;
            wr_pulse_reg <= 1'b0;
            tmo_pulse_reg <= 1'b0;
            if (sda_sync_reg[1]) begin
                low_cnt_reg <= 23'h000000;
            end else if (low_cnt_reg != TMO_CYC[22:0]) begin
                low_cnt_reg <= low_cnt_reg + 23'h000001;
            end
            if (low_cnt_reg == TMO_CYC[22:0] - 23'h000001) begin
                st_reg <= ST_IDLE;
                sda_oe_n_reg <= 1'b1;
                busy_reg <= 1'b0;
                tmo_pulse_reg <= 1'b1;
            end else if (start_cond) begin
                st_reg <= ST_ADDR;
                cnt_reg <= 4'hf; // Start's own clock fall wraps it to 0
                sda_oe_n_reg <= 1'b1;
                busy_reg <= 1'b1;
            end else if (stop_cond) begin
                st_reg <= ST_IDLE;
                sda_oe_n_reg <= 1'b1;
                busy_reg <= 1'b0;
            end else if (scl_rise && st_reg != ST_IDLE) begin
                if (cnt_reg < 4'h8) begin
                    sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
                end else begin
                    mack_reg <= ~sda_sync_reg[1];
                end
            end else if (scl_fall && st_reg != ST_IDLE) begin
                if (cnt_reg == 4'h7) begin
                    cnt_reg <= 4'h8;
                    case (st_reg)
                        ST_ADDR: sda_oe_n_reg <= ~addr_hit;
                        ST_WR: sda_oe_n_reg <= 1'b0;
                        ST_RD: begin
                            tx_reg <= {tx_reg[14:0], tx_reg[15]};
                            sda_oe_n_reg <= 1'b1;
                        end
                        default: sda_oe_n_reg <= 1'b1;
                    endcase
                end else if (cnt_reg == 4'h8) begin
                    cnt_reg <= 4'h0;
                    sda_oe_n_reg <= 1'b1;
                    case (st_reg)
                        ST_ADDR: begin
                            if (!addr_hit) begin
                                st_reg <= ST_IDLE;
                                busy_reg <= 1'b0;
                            end else if (sh_reg[0]) begin
                                st_reg <= ST_RD;
                                rd_pulse_reg <= 1'b1;
                                tx_reg <= rd_word;
                                sda_oe_n_reg <= rd_word[15];
                            end else begin
                                st_reg <= ST_WR;
                                idx_reg <= 2'h0;
                            end
                        end
                        ST_WR: begin
                            if (idx_reg == 2'h0) begin
                                ptr_reg <= sh_reg[1:0];
                            end else if (idx_reg == 2'h1) begin
                                wr_data_reg <= {sh_reg, 8'h00};
                                wr_pulse_reg <= (ptr_reg == `TAC_PTR_CFG);
                            end else begin
                                wr_data_reg <= {wr_data_reg[15:8], sh_reg};
                                wr_pulse_reg <= (ptr_reg != `TAC_PTR_CFG);
                            end
                            if (idx_reg != 2'h3) begin
                                idx_reg <= idx_reg + 2'h1;
                            end
                        end
                        ST_RD: begin
                            if (mack_reg) begin
                                sda_oe_n_reg <= tx_reg[15];
                            end else begin
                                st_reg <= ST_IDLE;
                                busy_reg <= 1'b0;
                            end
                        end
                        default: st_reg <= ST_IDLE;
                    endcase
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (st_reg == ST_RD) begin
                        tx_reg <= {tx_reg[14:0], tx_reg[15]};
                        sda_oe_n_reg <= tx_reg[14];
                    end
                end
            end
        end
    end
endmodule

// ===== rtl/tac_top.v
// Thermal alarm comparator: converter timing, comparator, alarm pin, APB registers
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "tac_defines.vh"
module tac_top #(
    parameter CONV_CYC = `TAC_CONV_CYC,
    parameter TMO_CYC = `TAC_TMO_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [8:0] adc_code,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output wire sda_oe_n,
    input wire [2:0] addr_pins,
    output reg alarm_o,
    output reg alarm_oe_n,
    output reg irq
);
    reg [8:0] temp_reg;
    reg [7:0] cfg_reg;
    reg [8:0] set_lim_reg;
    reg [8:0] clr_lim_reg;
    reg [3:0] stat_reg;
    reg [3:0] mask_reg;
    reg alarm_reg;
    reg arm_low_reg;
    reg [2:0] fault_cnt_reg;
    reg [22:0] conv_cnt_reg;
    reg conv_done_reg;
    reg sd_prev_reg;
    reg [15:0] rd_word;
    reg [31:0] apb_rd;
    reg apb_hit;
    wire [1:0] ptr;
    wire busy;
    wire host_rd;
    wire host_wr;
    wire [15:0] host_wdata;
    wire host_tmo;
    wire apb_wr;
    wire shutdown;
    wire int_mode;
    wire fault;
    wire trip;
    wire [3:0] events;

    // Queue depth code to consecutive fault count: 1, 2, 4, 6
    function [2:0] tac_fq_len;
        input [1:0] code;
        begin
            case (code)
                2'h0: tac_fq_len = 3'h1;
                2'h1: tac_fq_len = 3'h2;
                2'h2: tac_fq_len = 3'h4;
                default: tac_fq_len = 3'h6;
            endcase
        end
    endfunction

    // Signed compare of two half-degree codes
    function tac_gt;
        input [8:0] a;
        input [8:0] b;
        begin
            tac_gt = ($signed(a) > $signed(b));
        end
    endfunction

    tac_serial_slave #(
        .TMO_CYC(TMO_CYC)
    ) u_slave (
        .pclk(pclk),
        .presetn(presetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .addr_pins(addr_pins),
        .rd_word(rd_word),
        .sda_oe_n_reg(sda_oe_n),
        .ptr_reg(ptr),
        .busy_reg(busy),
        .rd_pulse_reg(host_rd),
        .wr_pulse_reg(host_wr),
        .wr_data_reg(host_wdata),
        .tmo_pulse_reg(host_tmo)
    );

    assign shutdown = cfg_reg[`TAC_CFG_SD];
    assign int_mode = cfg_reg[`TAC_CFG_INT];
    assign apb_wr = psel & penable & pready & pwrite;

    // Serial read word, 9-bit values left justified, config in high byte
    always @* begin
        case (ptr)
            `TAC_PTR_TEMP: rd_word = {temp_reg, 7'h00};
            `TAC_PTR_CFG: rd_word = {cfg_reg, 8'h00};
            `TAC_PTR_CLR: rd_word = {clr_lim_reg, 7'h00};
            default: rd_word = {set_lim_reg, 7'h00};
        endcase
    end

    // Conversion timer, cleared to zero while the host talks or in shutdown
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cnt_reg <= 23'h000000;
            conv_done_reg <= 1'b0;
            temp_reg <= 9'h000;
        end else begin
            conv_done_reg <= 1'b0;
            if (busy || shutdown) begin
                conv_cnt_reg <= 23'h000000;
            end else if (conv_cnt_reg == CONV_CYC[22:0] - 23'h000001) begin
                conv_cnt_reg <= 23'h000000;
                conv_done_reg <= 1'b1;
                temp_reg <= adc_code;
            end else begin
                conv_cnt_reg <= conv_cnt_reg + 23'h000001;
            end
        end
    end

    // Fault condition depends on the direction the comparator awaits
    assign fault = arm_low_reg ? tac_gt(clr_lim_reg, temp_reg) : tac_gt(temp_reg, set_lim_reg);
    assign trip = conv_done_reg & fault & (fault_cnt_reg + 3'h1 >= tac_fq_len(cfg_reg[4:3]));

    // Consecutive fault counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_cnt_reg <= 3'h0;
        end else if (conv_done_reg) begin
            if (!fault || trip) begin
                fault_cnt_reg <= 3'h0;
            end else begin
                fault_cnt_reg <= fault_cnt_reg + 3'h1;
            end
        end
    end

    // Alarm state in comparator and interrupt mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_reg <= 1'b0;
            arm_low_reg <= 1'b0;
            sd_prev_reg <= 1'b0;
        end else begin
            sd_prev_reg <= shutdown;
            if (trip) begin
                arm_low_reg <= ~arm_low_reg;
                if (int_mode) begin
                    alarm_reg <= 1'b1;
                end else begin
                    alarm_reg <= ~arm_low_reg;
                end
            end else if (int_mode && host_rd) begin
                alarm_reg <= 1'b0;
            end else if (int_mode && shutdown && !sd_prev_reg) begin
                alarm_reg <= 1'b0;
            end
        end
    end

    // Open-drain alarm pin, drawn low per polarity; shutdown leaves it alone in comparator mode, clears it in interrupt mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_o <= 1'b0;
            alarm_oe_n <= 1'b1;
            sda_o <= 1'b0;
        end else begin
            alarm_o <= 1'b0;
            sda_o <= 1'b0;
            alarm_oe_n <= ~(alarm_reg ^ cfg_reg[`TAC_CFG_POL]);
        end
    end

    // Configuration and limits, APB wins over the serial port
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= `TAC_RST_CFG;
            set_lim_reg <= `TAC_RST_SET;
            clr_lim_reg <= `TAC_RST_CLR;
            mask_reg <= 4'h0;
        end else if (apb_wr) begin
            case (paddr)
                `TAC_OFS_CFG: cfg_reg <= {3'h0, pwdata[4:0]};
                `TAC_OFS_CLR: clr_lim_reg <= pwdata[8:0];
                `TAC_OFS_SET: set_lim_reg <= pwdata[8:0];
                `TAC_OFS_MASK: mask_reg <= pwdata[3:0];
                default: mask_reg <= mask_reg;
            endcase
        end else if (host_wr) begin
            case (ptr)
                `TAC_PTR_CFG: cfg_reg <= {3'h0, host_wdata[12:8]};
                `TAC_PTR_CLR: clr_lim_reg <= host_wdata[15:7];
                `TAC_PTR_SET: set_lim_reg <= host_wdata[15:7];
                default: cfg_reg <= cfg_reg;
            endcase
        end
    end

    // Sticky events, set beats a write-one clear
    assign events = {host_tmo, host_rd, trip, conv_done_reg};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= 4'h0;
            irq <= 1'b0;
        end else begin
            if (apb_wr && paddr == `TAC_OFS_STAT) begin
                stat_reg <= (stat_reg & ~pwdata[3:0]) | events;
            end else begin
                stat_reg <= stat_reg | events;
            end
            irq <= |(stat_reg & mask_reg);
        end
    end

    // APB read mux and decode
    always @* begin
        apb_hit = 1'b1;
        case (paddr)
            `TAC_OFS_TEMP: apb_rd = {23'h000000, temp_reg};
            `TAC_OFS_CFG: apb_rd = {24'h000000, cfg_reg};
            `TAC_OFS_CLR: apb_rd = {23'h000000, clr_lim_reg};
            `TAC_OFS_SET: apb_rd = {23'h000000, set_lim_reg};
            `TAC_OFS_STAT: apb_rd = {28'h0000000, stat_reg};
            `TAC_OFS_MASK: apb_rd = {28'h0000000, mask_reg};
            `TAC_OFS_ALARM: apb_rd = {25'h0000000, fault_cnt_reg, 2'h0, arm_low_reg, alarm_reg};
            default: begin
                apb_rd = 32'h00000000;
                apb_hit = 1'b0;
            end
        endcase
    end

    // APB slave, one wait-free access cycle after setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= ~apb_hit;
            prdata <= pwrite ? 32'h00000000 : apb_rd;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule

// ===== shared/tac_defines.vh
// Constants for the thermal alarm comparator: offsets, fields, resets, timing
`ifndef TAC_DEFINES_VH
`define TAC_DEFINES_VH

// APB byte offsets
`define TAC_OFS_TEMP 8'h00
`define TAC_OFS_CFG 8'h04
`define TAC_OFS_CLR 8'h08
`define TAC_OFS_SET 8'h0c
`define TAC_OFS_STAT 8'h10
`define TAC_OFS_MASK 8'h14
`define TAC_OFS_ALARM 8'h18

// Configuration fields
`define TAC_CFG_SD 0
`define TAC_CFG_INT 1
`define TAC_CFG_POL 2
`define TAC_CFG_FQ_LO 3
`define TAC_CFG_FQ_HI 4

// Status and mask bits
`define TAC_ST_CONV 0
`define TAC_ST_ALARM 1
`define TAC_ST_READ 2
`define TAC_ST_TMO 3

// Reset values, 80 and 75 degrees in half-degree steps
`define TAC_RST_CFG 8'h00
`define TAC_RST_SET 9'h0a0
`define TAC_RST_CLR 9'h096

// Serial pointer codes and address
`define TAC_PTR_TEMP 2'h0
`define TAC_PTR_CFG 2'h1
`define TAC_PTR_CLR 2'h2
`define TAC_PTR_SET 2'h3
`define TAC_ADDR_HI 4'h9

// Timing
`define TAC_CLK_KHZ 50000
`define TAC_CONV_MS 100
`define TAC_TMO_MIN_MS 75
`define TAC_TMO_MAX_MS 325
`define TAC_CONV_CYC (`TAC_CONV_MS * `TAC_CLK_KHZ)
`define TAC_TMO_CYC (`TAC_TMO_MIN_MS * `TAC_CLK_KHZ)

`endif

// ===== verif/tac_assertions.sv
// Port-level checker for the thermal alarm comparator, bound into the top
`timescale 1ns/100ps
`include "tac_defines.vh"
module tac_checker #(
    parameter CONV_CYC = 200,
    parameter TMO_CYC = 400
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire sda_i,
    input wire sda_oe_n,
    input wire alarm_oe_n,
    input wire irq
);
    reg pol_q;
    reg [3:0] mask_q;
    integer lo_cnt;
    wire wr_hit = psel && penable && pready && pwrite;
    // Shadow of polarity and mask, and low time of the data line
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_q <= 1'b0;
            mask_q <= 4'h0;
            lo_cnt <= 0;
        end else begin
            if (wr_hit && paddr == `TAC_OFS_CFG) begin
                pol_q <= pwdata[`TAC_CFG_POL];
            end
            if (wr_hit && paddr == `TAC_OFS_MASK) begin
                mask_q <= pwdata[3:0];
            end
            if (sda_i) begin
                lo_cnt <= 0;
            end else if (lo_cnt < TMO_CYC + 100) begin
                lo_cnt <= lo_cnt + 1;
            end
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_setup_answer: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_decode: assert property (pready && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > `TAC_OFS_ALARM))
        else $error("error flag does not match address");
    chk_unmapped_zero: assert property (pready && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_temp_width: assert property (pready && !pwrite && paddr == `TAC_OFS_TEMP
        |-> prdata[31:9] == 23'h0)
        else $error("temperature wider than nine bits");
    chk_irq_masked: assert property ((mask_q == 4'h0)[*3] |-> !irq)
        else $error("irq high with all masked");
    chk_stuck_release: assert property (lo_cnt >= TMO_CYC + 16 |-> sda_oe_n)
        else $error("data line held past timeout");
    chk_pol_follow: assert property ($changed(pol_q) |-> ##[1:3] $changed(alarm_oe_n))
        else $error("alarm pin ignores polarity");
    cover property (pslverr);
    cover property (!alarm_oe_n);
    cover property ($fell(sda_oe_n));
endmodule

bind tac_top tac_checker #(.CONV_CYC(CONV_CYC), .TMO_CYC(TMO_CYC)) tac_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sda_i(sda_i), .sda_oe_n(sda_oe_n), .alarm_oe_n(alarm_oe_n), .irq(irq)
);

// ===== verif/tac_host_model.sv
// Two-wire bus master model that clocks the link of the comparator
`timescale 1ns/100ps
`include "tac_defines.vh"
module tac_host_model #(
    parameter QT = 40
) (
    input wire sda_oe_n,
    output wire scl,
    output wire sda
);
    reg scl_q = 1'b1;
    reg sda_q = 1'b1;
    // Pulled-up data line, clock parked high; pins lag by 5 ns, off pclk edges
    assign #5 scl = scl_q;
    assign #5 sda = sda_q & sda_oe_n;
    // One bit: set while clock low, sampled while high
    task automatic clk_bit(input reg b, output reg r);
        #QT sda_q = b;
        #QT scl_q = 1'b1;
        #QT r = sda;
        #QT scl_q = 1'b0;
    endtask
    // Start and stop conditions
    task automatic start_cond;
        #QT sda_q = 1'b0;
        #QT scl_q = 1'b0;
    endtask
    task automatic stop_cond;
        #QT sda_q = 1'b0;
        #QT scl_q = 1'b1;
        #QT sda_q = 1'b1;
        #QT;
    endtask
    // Eight bits out or in, then the acknowledge bit
    task automatic xfer(input [7:0] d, input reg ai, output reg [7:0] q, output reg ack);
        integer i;
        reg r;
        for (i = 7; i >= 0; i = i - 1) begin
            clk_bit(d[i], r);
            q[i] = r;
        end
        clk_bit(ai, ack);
    endtask
    // Two-byte read from the current pointer, ended by a not-acknowledge
    task automatic read_word(input [2:0] a, output reg [15:0] w, output reg ack);
        reg x;
        start_cond;
        xfer({`TAC_ADDR_HI, a, 1'b1}, 1'b1, w[15:8], ack);
        if (ack === 1'b0) begin
            xfer(8'hff, 1'b0, w[15:8], x);
            xfer(8'hff, 1'b1, w[7:0], x);
        end
        stop_cond;
    endtask
    // Address and one data bit, then the clock stops low mid-byte
    task automatic stall_read(input [2:0] a);
        reg [7:0] q;
        reg x;
        start_cond;
        xfer({`TAC_ADDR_HI, a, 1'b1}, 1'b1, q, x);
        clk_bit(1'b1, x);
    endtask
endmodule

// ===== verif/test_thermal_alarm_comparator.sv
// Self-checking bench for the thermal alarm comparator
`timescale 1ns/100ps
`include "tac_defines.vh"
module test_thermal_alarm_comparator;
    localparam CONV = 200;
    localparam TMO = 400;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [8:0] adc_code = 9'h000;
    reg [2:0] addr_pins = 3'h5;
    wire [31:0] prdata;
    wire pready, pslverr, sda_o, sda_oe_n, alarm_o, alarm_oe_n, irq, scl_i, sda_i;
    integer err_count = 0;
    integer total_checks = 0;
    integer k;
    reg [31:0] q;
    reg [15:0] w;
    reg ack;
    tac_top #(.CONV_CYC(CONV), .TMO_CYC(TMO)) tac_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_code(adc_code), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .addr_pins(addr_pins), .alarm_o(alarm_o),
        .alarm_oe_n(alarm_oe_n), .irq(irq)
    );
    tac_host_model tac_host_model_i (.sda_oe_n(sda_oe_n), .scl(scl_i), .sda(sda_i));
    // Clock
    initial begin
        forever #10 pclk = ~pclk;
    end
    // Compare and count
    task automatic chk(input [31:0] seen, input [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test;
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One bus transfer: setup, then access until ready
    task automatic rw(input reg wn, input [7:0] a, input [31:0] d, output [31:0] r, output reg e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wn;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        reg [31:0] r;
        reg e;
        rw(1'b1, a, d, r, e);
    endtask
    task automatic rd(input [7:0] a, output [31:0] r);
        reg e;
        rw(1'b0, a, 32'h0, r, e);
    endtask
    task automatic cyc(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    // Present a code and wait for n finished conversions
    task automatic conv(input [8:0] code, input integer n);
        integer i, p;
        reg [31:0] r;
        adc_code <= code;
        for (i = 0; i < n; i = i + 1) begin
            wr(`TAC_OFS_STAT, 32'h1);
            p = 0;
            r = 32'h0;
            while (r[0] !== 1'b1 && p < 200) begin
                rd(`TAC_OFS_STAT, r);
                p = p + 1;
            end
            chk(r[0], 1'b1);
        end
        cyc(3);
    endtask
    // Reset values, read-only and unmapped places
    task automatic t_reset;
        chk(alarm_oe_n, 1'b1);
        chk(sda_oe_n, 1'b1);
        chk({alarm_o, sda_o}, 2'h0);
        rd(`TAC_OFS_CFG, q);
        chk(q, 32'h0);
        rd(`TAC_OFS_SET, q);
        chk(q, 32'h0a0);
        rd(`TAC_OFS_CLR, q);
        chk(q, 32'h096);
        wr(`TAC_OFS_TEMP, 32'h55);
        rd(`TAC_OFS_TEMP, q);
        chk(q, 32'h0);
        rw(1'b0, 8'h1c, 32'h0, q, ack);
        chk(q, 32'h0);
        chk(ack, 1'b1);
    endtask
    // Negative result stored, conversion interrupt raised, masked, cleared
    task automatic t_convert;
        conv(9'h1ce, 1);
        rd(`TAC_OFS_TEMP, q);
        chk(q, 32'h1ce);
        wr(`TAC_OFS_MASK, 32'h1);
        cyc(2);
        chk(irq, 1'b1);
        wr(`TAC_OFS_MASK, 32'h0);
        cyc(2);
        chk(irq, 1'b0);
        wr(`TAC_OFS_MASK, 32'h1);
        wr(`TAC_OFS_STAT, 32'h1);
        cyc(2);
        chk(irq, 1'b0);
        wr(`TAC_OFS_MASK, 32'h0);
    endtask
    // Comparator: every fault count, broken runs, hysteresis, shutdown, polarity
    task automatic t_comparator;
        integer n;
        for (k = 0; k < 4; k = k + 1) begin
            n = (k == 3) ? 6 : (1 << k);
            wr(`TAC_OFS_CFG, k << `TAC_CFG_FQ_LO);
            conv(9'h0a1, n - 1);
            chk(alarm_oe_n, 1'b1);
            conv(9'h0a1, 1);
            chk(alarm_oe_n, 1'b0);
            conv(9'h095, n);
            chk(alarm_oe_n, 1'b1);
        end
        conv(9'h0a1, 5);
        conv(9'h0a0, 1);
        conv(9'h0a1, 5);
        chk(alarm_oe_n, 1'b1);
        conv(9'h0a1, 1);
        chk(alarm_oe_n, 1'b0);
        wr(`TAC_OFS_CFG, 32'h19);
        cyc(CONV + 20);
        chk(alarm_oe_n, 1'b0);
        wr(`TAC_OFS_CFG, 32'h18);
        conv(9'h097, 6);
        chk(alarm_oe_n, 1'b0);
        conv(9'h095, 6);
        chk(alarm_oe_n, 1'b1);
        wr(`TAC_OFS_CFG, 32'h04);
        cyc(3);
        chk(alarm_oe_n, 1'b0);
        conv(9'h0a1, 1);
        chk(alarm_oe_n, 1'b1);
        wr(`TAC_OFS_CFG, 32'h00);
        cyc(3);
        chk(alarm_oe_n, 1'b0);
        conv(9'h095, 1);
    endtask
    // Interrupt mode: hold, cleared by serial read, re-arm low, shutdown clear
    task automatic t_interrupt;
        wr(`TAC_OFS_CFG, 32'h02);
        conv(9'h0a1, 1);
        chk(alarm_oe_n, 1'b0);
        conv(9'h0a1, 2);
        chk(alarm_oe_n, 1'b0);
        tac_host_model_i.read_word(3'h5, w, ack);
        chk(w, 16'h5080);
        cyc(4);
        chk(alarm_oe_n, 1'b1);
        conv(9'h0a1, 2);
        chk(alarm_oe_n, 1'b1);
        conv(9'h095, 1);
        chk(alarm_oe_n, 1'b0);
        wr(`TAC_OFS_CFG, 32'h03);
        cyc(4);
        chk(alarm_oe_n, 1'b1);
        wr(`TAC_OFS_CFG, 32'h00);
    endtask
    // Serial read aborts a conversion near its end; wrong address refused
    task automatic t_serial;
        conv(9'h032, 1);
        adc_code <= 9'h1ff;
        wr(`TAC_OFS_STAT, 32'h7);
        cyc(CONV - 60);
        tac_host_model_i.read_word(3'h5, w, ack);
        chk(ack, 1'b0);
        chk(w, 16'h1900);
        rd(`TAC_OFS_STAT, q);
        chk(q[2:0], 3'h4);
        rd(`TAC_OFS_TEMP, q);
        chk(q, 32'h032);
        conv(9'h1ff, 1);
        rd(`TAC_OFS_TEMP, q);
        chk(q, 32'h1ff);
        tac_host_model_i.read_word(3'h2, w, ack);
        chk(ack, 1'b1);
    endtask
    // Device left holding the data line low until the bus timeout
    task automatic t_timeout;
        conv(9'h032, 1);
        wr(`TAC_OFS_MASK, 32'h8);
        wr(`TAC_OFS_STAT, 32'hf);
        tac_host_model_i.stall_read(3'h5);
        cyc(8);
        chk(sda_oe_n, 1'b0);
        cyc(TMO + 40);
        chk(sda_oe_n, 1'b1);
        chk(irq, 1'b1);
        rd(`TAC_OFS_STAT, q);
        chk(q[3], 1'b1);
        tac_host_model_i.stop_cond;
        wr(`TAC_OFS_STAT, 32'h8);
        wr(`TAC_OFS_MASK, 32'h0);
        tac_host_model_i.read_word(3'h5, w, ack);
        chk(ack, 1'b0);
    endtask
    // Main sequence
    initial begin
        cyc(10);
        presetn <= 1'b1;
        t_reset;
        t_convert;
        t_comparator;
        t_interrupt;
        t_serial;
        t_timeout;
        stop_test;
    end
    // Watchdog
    initial begin
        #2000000;
        err_count = err_count + 1;
        stop_test;
    end
endmodule
